// [pac_cmd_decode.v]
`timescale 1ns/10ps
`include "pac_defs.vh"
module pac_cmd_decode (
	input  wire       i_clock,
	input  wire       i_rst,
	input  wire [1:0] i_op_enable_pair,
	input  wire       i_op_write_select,
	input  wire [2:0] i_op_code_field,
	input  wire [5:0] i_pixel_port_address,
	input  wire [3:0] i_byte_lane_enables,
	output reg        o_pb_read_q,
	output reg        o_ident_read_q,
	output reg        o_reg_write_q,
	output reg        o_data_write_q,
	output reg        o_stateful_q,
	output reg        o_initial_q,
	output reg        o_tag_replace_q,
	output reg        o_tag_or_q,
	output reg        o_blend_init_q,
	output reg  [5:0] o_addr_q,
	output reg  [3:0] o_be_q
);

	// ----------------------------------------------------------------
	// stage 2 decode of the pins sampled at the edge
	// ----------------------------------------------------------------
	wire act = (i_op_enable_pair == `PAC_EN_ACTIVE);
	wire rd  = act & ~i_op_write_select;
	wire wr  = act & i_op_write_select;
	wire op_reg = (i_op_code_field == `PAC_OP_REG_ACCESS);

	always @(posedge i_clock) begin
		if (i_rst) begin
			o_pb_read_q     <= 1'b0;
			o_ident_read_q  <= 1'b0;
			o_reg_write_q   <= 1'b0;
			o_data_write_q  <= 1'b0;
			o_stateful_q    <= 1'b0;
			o_initial_q     <= 1'b0;
			o_tag_replace_q <= 1'b0;
			o_tag_or_q      <= 1'b0;
			o_blend_init_q  <= 1'b0;
			o_addr_q        <= 6'h00;
			o_be_q          <= 4'h0;
		end else begin
			// reserved read opcodes fall through as no-operations
			o_pb_read_q    <= rd & (i_op_code_field == `PAC_OP_PB_READ);
			o_ident_read_q <= rd & op_reg &
				(i_pixel_port_address == `PAC_A_IDENT);
			o_reg_write_q  <= wr & op_reg;
			o_data_write_q <= wr & ~i_op_code_field[2];
			o_stateful_q   <= i_op_code_field[1];
			o_initial_q    <= ~i_op_code_field[0];
			o_tag_replace_q <= wr & (i_op_code_field == `PAC_OP_TAG_REPLACE);
			o_tag_or_q     <= wr & (i_op_code_field == `PAC_OP_TAG_OR);
			o_blend_init_q <= wr & (i_op_code_field == `PAC_OP_BLEND_INIT);
			o_addr_q       <= i_pixel_port_address;
			o_be_q         <= i_byte_lane_enables;
		end
	end

endmodule

// [pac_defs.vh]
`ifndef PAC_DEFS_VH
`define PAC_DEFS_VH

// ----------------------------------------------------------------
// register indices (six-bit port address)
// ----------------------------------------------------------------
`define PAC_A_PLANE_MASK      6'h00
`define PAC_A_CONST_OPERAND   6'h01
`define PAC_A_EQ_MASK         6'h02
`define PAC_A_ORDER_MASK      6'h03
`define PAC_A_RASTER_BLEND    6'h04
`define PAC_A_COMPARE_PICK    6'h05
`define PAC_A_WRITE_ADDR      6'h06
`define PAC_A_IDENT           6'h07
`define PAC_A_SECOND_BLEND    6'h08
`define PAC_A_PRE_BLEND       6'h09
`define PAC_A_STENCIL_PLANE   6'h0a
`define PAC_A_STENCIL_FUNC    6'h0b
`define PAC_A_PASS_SELECT     6'h0e
`define PAC_A_DEPTH_SELECT    6'h0f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PAC_RST_PLANE_MASK    32'hffff_ffff
`define PAC_RST_RASTER_BLEND  32'h0303_0303
`define PAC_RST_COMPARE_PICK  32'h0a00_0000
`define PAC_RST_STENCIL_PLANE 32'h00ff_0000
`define PAC_RST_STENCIL_FUNC  32'h3330_0000
`define PAC_RST_PASS_SELECT   32'h0000_0100
`define PAC_RST_ZERO          32'h0000_0000
`define PAC_RST_CONST_EXT     4'h0

// ----------------------------------------------------------------
// fixed values used during stateless writes
// ----------------------------------------------------------------
`define PAC_SL_RASTER_BLEND   32'h0303_0303
`define PAC_SL_STENCIL_PLANE  32'h00ff_0000
`define PAC_SL_STENCIL_FUNC   32'h3330_0000
`define PAC_SL_ZERO           32'h0000_0000

// ----------------------------------------------------------------
// opcodes and enables
// ----------------------------------------------------------------
`define PAC_EN_ACTIVE         2'h3
`define PAC_OP_PB_READ        3'h0
`define PAC_OP_REG_ACCESS     3'h7
`define PAC_OP_TAG_REPLACE    3'h4
`define PAC_OP_TAG_OR         3'h5
`define PAC_OP_BLEND_INIT     3'h6

// ----------------------------------------------------------------
// compare/pick control fields
// ----------------------------------------------------------------
`define PAC_PICK_EN_LOAD      27
`define PAC_PICK_EN_VAL       26
`define PAC_PICK_HIT_LOAD     25
`define PAC_PICK_HIT_VAL      24

// ----------------------------------------------------------------
// pipeline timing in clock edges
// ----------------------------------------------------------------
`define PAC_STAGE6_DELAY      4
`define PAC_STAGE7_DELAY      5

// arbitrary neutral identification value, bit 0 forced to one
`define PAC_IDENT_DEFAULT     32'h0012_3401

`endif

// [pac_delay.v]
`timescale 1ns/10ps
module pac_delay #(
	parameter WIDTH = 1,
	parameter DEPTH = 1
) (
	input  wire             i_clock,
	input  wire             i_rst,
	input  wire [WIDTH-1:0] i_data,
	output wire [WIDTH-1:0] o_data
);

	// ----------------------------------------------------------------
	// shift chain, one flop stage per entry
	// ----------------------------------------------------------------
	reg [WIDTH-1:0] stage_q [0:DEPTH-1];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_stage
			always @(posedge i_clock) begin
				if (i_rst) begin
					stage_q[g] <= {WIDTH{1'b0}};
				end else if (g == 0) begin
					stage_q[g] <= i_data;
				end else begin
					stage_q[g] <= stage_q[(g == 0) ? 0 : g - 1];
				end
			end
		end
	endgenerate

	assign o_data = stage_q[DEPTH-1];

endmodule

// [pac_far_model.sv]
`timescale 1ns/10ps
module pac_far_model (
	input  wire        i_clock,
	input  wire        i_pb_read_q,
	input  wire [5:0]  i_cmd_addr_q,
	input  wire        i_pass_want,
	input  wire [1:0]  i_drop_sel,
	output reg  [31:0] o_pb_read_data,
	output wire        o_match_result,
	output wire        o_order_result,
	output wire [1:0]  o_pass_in
);
	// ----------------------------------------------------------------
	// pixel buffer and compare side
	// ----------------------------------------------------------------
	reg  [31:0] last_q = 32'h0000_0000;
	wire [3:0]  drop = i_pass_want ? 4'h0 : 4'h1 << i_drop_sel;
	// outside the strobe the word inverts every cycle, so stale data differs from the last read word on alternate cycles only
	always @* o_pb_read_data = i_pb_read_q ? {4{2'b10, i_cmd_addr_q}} : ~last_q;
	always @(posedge i_clock) last_q <= o_pb_read_data;
	// a failing test drops exactly one of the four pass terms
	assign o_match_result = ~drop[0];
	assign o_order_result = ~drop[1];
	assign o_pass_in      = ~drop[3:2];
endmodule

// [pac_top.v]
`timescale 1ns/10ps
`include "pac_defs.vh"
module pac_top #(
	parameter [31:0] IDENT_VALUE = `PAC_IDENT_DEFAULT
) (
	input  wire         i_clock,
	input  wire         i_rst,
	input  wire [1:0]   i_op_enable_pair,
	input  wire         i_op_write_select,
	input  wire [2:0]   i_op_code_field,
	input  wire [5:0]   i_pixel_port_address,
	input  wire [3:0]   i_byte_lane_enables,
	input  wire [31:0]  i_pixel_data_bus,
	input  wire [3:0]   i_data_extension_bits,
	input  wire [31:0]  i_pb_read_data,
	input  wire         i_match_result,
	input  wire         i_order_result,
	input  wire [1:0]   i_pass_in,
	output reg  [31:0]  o_pixel_data_bus,
	output reg          o_pixel_data_oe,
	output wire         o_pb_read_q,
	output wire [5:0]   o_cmd_addr_q,
	output reg          o_wr_valid_q,
	output reg          o_wr_stateful_q,
	output reg          o_wr_initial_q,
	output reg          o_tag_replace_q,
	output reg          o_tag_or_q,
	output reg          o_blend_init_q,
	output reg  [2:0]   o_wr_block_q,
	output reg  [2:0]   o_wr_word_q,
	output reg  [31:0]  o_wr_data_q,
	output reg  [3:0]   o_wr_ext_q,
	output reg  [31:0]  o_wr_bit_en_q,
	output reg  [511:0] o_stage_ctrl_q,
	output reg  [31:0]  o_plane_write_mask_q,
	output reg  [35:0]  o_constant_operand_q,
	output reg          o_pass_out_q,
	output reg          o_pb_write_enable_q,
	output reg          o_pick_enable_q,
	output reg          o_hit_n_q
);

	// ----------------------------------------------------------------
	// stage 2 command decode
	// ----------------------------------------------------------------
	wire       ident_read;
	wire       reg_write;
	wire       data_write;
	wire       stateful;
	wire       initial_mode;
	wire       tag_replace;
	wire       tag_or;
	wire       blend_init;
	wire [3:0] be;

	pac_cmd_decode u_decode (
		.i_clock              (i_clock),
		.i_rst                (i_rst),
		.i_op_enable_pair     (i_op_enable_pair),
		.i_op_write_select    (i_op_write_select),
		.i_op_code_field      (i_op_code_field),
		.i_pixel_port_address (i_pixel_port_address),
		.i_byte_lane_enables  (i_byte_lane_enables),
		.o_pb_read_q          (o_pb_read_q),
		.o_ident_read_q       (ident_read),
		.o_reg_write_q        (reg_write),
		.o_data_write_q       (data_write),
		.o_stateful_q         (stateful),
		.o_initial_q          (initial_mode),
		.o_tag_replace_q      (tag_replace),
		.o_tag_or_q           (tag_or),
		.o_blend_init_q       (blend_init),
		.o_addr_q             (o_cmd_addr_q),
		.o_be_q               (be)
	);

	// ----------------------------------------------------------------
	// register file, one entry per slot 0x00-0x0f of the six-bit address
	// ----------------------------------------------------------------
	// write data arrives the cycle after the opcode, so the load happens
	// at the end of stage 2; ops already past stage 2 keep old values
	reg  [31:0] reg_q [0:15];
	wire [31:0] lane_mask = {{8{be[3]}}, {8{be[2]}},
		{8{be[1]}}, {8{be[0]}}};

	function [31:0] pac_rst_val;
		input [3:0] idx;
		begin
			case (idx)
			4'h0:    pac_rst_val = `PAC_RST_PLANE_MASK;
			4'h4:    pac_rst_val = `PAC_RST_RASTER_BLEND;
			4'h5:    pac_rst_val = `PAC_RST_COMPARE_PICK;
			4'ha:    pac_rst_val = `PAC_RST_STENCIL_PLANE;
			4'hb:    pac_rst_val = `PAC_RST_STENCIL_FUNC;
			4'he:    pac_rst_val = `PAC_RST_PASS_SELECT;
			default: pac_rst_val = `PAC_RST_ZERO;
			endcase
		end
	endfunction

	function pac_implemented;
		input [3:0] idx;
		begin
			case (idx)
			4'h7:    pac_implemented = 1'b0;
			4'hc:    pac_implemented = 1'b0;
			4'hd:    pac_implemented = 1'b0;
			default: pac_implemented = 1'b1;
			endcase
		end
	endfunction

	// stateless writes see fixed values; the three masks, constant and the
	// depth/pass selects keep their contents
	function [31:0] pac_stateless_val;
		input [3:0]  idx;
		input [31:0] cur;
		begin
			case (idx)
			4'h4:    pac_stateless_val = `PAC_SL_RASTER_BLEND;
			4'h5:    pac_stateless_val = `PAC_SL_ZERO;
			4'h6:    pac_stateless_val = `PAC_SL_ZERO;
			4'h8:    pac_stateless_val = `PAC_SL_ZERO;
			4'h9:    pac_stateless_val = `PAC_SL_ZERO;
			4'ha:    pac_stateless_val = `PAC_SL_STENCIL_PLANE;
			4'hb:    pac_stateless_val = `PAC_SL_STENCIL_FUNC;
			default: pac_stateless_val = cur;
			endcase
		end
	endfunction

	// register slots beyond 0x0f do not exist; the write is dropped
	wire reg_hit_range = (o_cmd_addr_q[5:4] == 2'b00);
	wire stage_stateless = data_write & ~stateful;

	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_reg
			wire sel = reg_write & reg_hit_range &
				(o_cmd_addr_q[3:0] == g) & pac_implemented(g);
			wire [31:0] merged = (reg_q[g] & ~lane_mask) |
				(i_pixel_data_bus & lane_mask);
			always @(posedge i_clock) begin
				if (i_rst) begin
					reg_q[g] <= pac_rst_val(g);
				end else if (sel) begin
					reg_q[g] <= merged;
				end else if (g == 5) begin
					// one-shot pick controls drop back to no change
					reg_q[g][`PAC_PICK_EN_LOAD]  <= 1'b0;
					reg_q[g][`PAC_PICK_HIT_LOAD] <= 1'b0;
				end
			end
			// snapshot for the op entering stage 3 on this edge
			always @(posedge i_clock) begin
				if (i_rst) begin
					o_stage_ctrl_q[32*g +: 32] <= pac_rst_val(g);
				end else if (stage_stateless) begin
					o_stage_ctrl_q[32*g +: 32] <=
						pac_stateless_val(g, reg_q[g]);
				end else begin
					o_stage_ctrl_q[32*g +: 32] <= reg_q[g];
				end
			end
		end
	endgenerate

	wire const_sel = reg_write & reg_hit_range &
		(o_cmd_addr_q[3:0] == `PAC_A_CONST_OPERAND);
	// top nibble staged beside reg_q so all 36 bits change together
	reg  [3:0]  const_ext_q;

	always @(posedge i_clock) begin
		if (i_rst) begin
			o_plane_write_mask_q <= `PAC_RST_PLANE_MASK;
			o_constant_operand_q <= {`PAC_RST_CONST_EXT, `PAC_RST_ZERO};
			const_ext_q          <= `PAC_RST_CONST_EXT;
		end else begin
			// mirrors the mask to the DRAM masked block write path
			o_plane_write_mask_q <= reg_q[0];
			o_constant_operand_q <= {const_ext_q, reg_q[1]};
			if (const_sel & be[3]) begin
				const_ext_q <= i_data_extension_bits;
			end
		end
	end

	// ----------------------------------------------------------------
	// read path: pixel buffer word or identification, in stage 3
	// ----------------------------------------------------------------
	wire [31:0] ident_word = {IDENT_VALUE[31:1], 1'b1};

	always @(posedge i_clock) begin
		if (i_rst) begin
			o_pixel_data_bus <= 32'h0000_0000;
			o_pixel_data_oe  <= 1'b0;
		end else begin
			o_pixel_data_oe <= o_pb_read_q | ident_read;
			if (ident_read) begin
				o_pixel_data_bus <= ident_word & lane_mask;
			end else if (o_pb_read_q) begin
				o_pixel_data_bus <= i_pb_read_data;
			end else begin
				o_pixel_data_bus <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// stage 3 write group: data taken on the edge after the opcode
	// ----------------------------------------------------------------
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_wr_valid_q    <= 1'b0;
			o_wr_stateful_q <= 1'b0;
			o_wr_initial_q  <= 1'b0;
			o_tag_replace_q <= 1'b0;
			o_tag_or_q      <= 1'b0;
			o_blend_init_q  <= 1'b0;
			o_wr_block_q    <= 3'h0;
			o_wr_word_q     <= 3'h0;
			o_wr_data_q     <= 32'h0000_0000;
			o_wr_ext_q      <= 4'h0;
			o_wr_bit_en_q   <= 32'h0000_0000;
		end else begin
			o_wr_valid_q    <= data_write;
			o_wr_stateful_q <= data_write & stateful;
			o_wr_initial_q  <= data_write & initial_mode;
			o_tag_replace_q <= tag_replace;
			o_tag_or_q      <= tag_or;
			o_blend_init_q  <= blend_init;
			o_wr_block_q    <= o_cmd_addr_q[5:3];
			// tag ops carry no word address
			o_wr_word_q     <= (tag_replace | tag_or) ? 3'h0 :
				o_cmd_addr_q[2:0];
			o_wr_data_q     <= i_pixel_data_bus;
			o_wr_ext_q      <= i_data_extension_bits;
			if (data_write & stateful) begin
				o_wr_bit_en_q <= reg_q[0];
			end else if (data_write) begin
				o_wr_bit_en_q <= 32'hffff_ffff;
			end else begin
				o_wr_bit_en_q <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// compare pass and pixel buffer write enable
	// ----------------------------------------------------------------
	wire [1:0] wr_at6;
	wire [3:0] pick_at7;

	pac_delay #(
		.WIDTH (2),
		.DEPTH (`PAC_STAGE6_DELAY)
	) u_wr_pipe (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_data  ({data_write, data_write & stateful}),
		.o_data  (wr_at6)
	);

	// compare results are final in stage 5, pass out shows in stage 6
	wire pass_all = o_pass_out_q & i_pass_in[0] & i_pass_in[1];
	reg  hit_req_q;

	always @(posedge i_clock) begin
		if (i_rst) begin
			o_pass_out_q        <= 1'b0;
			o_pb_write_enable_q <= 1'b0;
			hit_req_q           <= 1'b0;
		end else begin
			o_pass_out_q <= i_match_result & i_order_result;
			// stateless writes bypass the compare units
			o_pb_write_enable_q <= wr_at6[1] &
				(pass_all | ~wr_at6[0]);
			hit_req_q <= wr_at6[0] & pass_all;
		end
	end

	// ----------------------------------------------------------------
	// picking logic, both event kinds meet in stage 7
	// ----------------------------------------------------------------
	wire ccr_byte3 = reg_write & reg_hit_range & be[3] &
		(o_cmd_addr_q[3:0] == `PAC_A_COMPARE_PICK);
	// decoded straight from the incoming data, so the one-shot timing
	// of the stored bits cannot drop or repeat an action
	wire [3:0] pick_evt = {ccr_byte3 & i_pixel_data_bus[`PAC_PICK_EN_LOAD],
		i_pixel_data_bus[`PAC_PICK_EN_VAL],
		ccr_byte3 & i_pixel_data_bus[`PAC_PICK_HIT_LOAD],
		i_pixel_data_bus[`PAC_PICK_HIT_VAL]};

	pac_delay #(
		.WIDTH (4),
		.DEPTH (`PAC_STAGE7_DELAY)
	) u_pick_pipe (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_data  (pick_evt),
		.o_data  (pick_at7)
	);

	// ops reach stage 7 in issue order, so a clear issued ahead of a
	// stateful write always lands first
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_pick_enable_q <= 1'b1;
			o_hit_n_q       <= 1'b1;
		end else begin
			if (pick_at7[3]) begin
				o_pick_enable_q <= pick_at7[2];
			end
			if (pick_at7[1]) begin
				o_hit_n_q <= ~pick_at7[0];
			end else if (hit_req_q & o_pick_enable_q) begin
				o_hit_n_q <= 1'b0;
			end
		end
	end

endmodule

// [pac_top_assertions.sv]
`timescale 1ns/10ps
`include "pac_defs.vh"
module pac_top_checker (
	input wire        i_clock,
	input wire        i_rst,
	input wire [1:0]  i_op_enable_pair,
	input wire        i_op_write_select,
	input wire [2:0]  i_op_code_field,
	input wire [5:0]  i_pixel_port_address,
	input wire [3:0]  i_byte_lane_enables,
	input wire [31:0] i_pixel_data_bus,
	input wire [1:0]  i_pass_in,
	input wire        o_pixel_data_oe,
	input wire        o_pb_read_q,
	input wire [5:0]  o_cmd_addr_q,
	input wire        o_wr_valid_q,
	input wire        o_wr_stateful_q,
	input wire        o_wr_initial_q,
	input wire        o_tag_replace_q,
	input wire        o_tag_or_q,
	input wire        o_blend_init_q,
	input wire [2:0]  o_wr_word_q,
	input wire [31:0] o_plane_write_mask_q,
	input wire        o_pass_out_q,
	input wire        o_pb_write_enable_q,
	input wire        o_pick_enable_q,
	input wire        o_hit_n_q
);
	default clocking dc @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	wire [2:0] op = i_op_code_field;
	wire [5:0] ad = i_pixel_port_address;
	wire act = &i_op_enable_pair;
	wire rd = act & ~i_op_write_select;
	wire wr = act & i_op_write_select;
	wire rw = wr & (&op);
	wire ccr_wr = rw & ad == `PAC_A_COMPARE_PICK & i_byte_lane_enables[3];
	wire [3:0] b = i_byte_lane_enables;
	wire [31:0] bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	sequence clr_s;
		ccr_wr ##1 i_pixel_data_bus[25:24] == 2'b10;
	endsequence
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	nop_idle_a: assert property (!act |=> !o_pb_read_q ##1
		!(o_wr_valid_q | o_tag_replace_q | o_tag_or_q | o_blend_init_q))
		else $error("nop decoded");
	pb_read_a: assert property (rd & op == 3'h0 |=> o_pb_read_q
		&& o_cmd_addr_q == $past(ad)) else $error("read strobe");
	read_answer_a: assert property (rd & (op == 3'h0
		| op == 3'h7 & ad == `PAC_A_IDENT) |-> ##2 o_pixel_data_oe
		##1 !o_pixel_data_oe) else $error("read answer");
	write_mode_a: assert property (wr & ~op[2] |-> ##2 o_wr_valid_q
		&& o_wr_stateful_q == $past(op[1], 2)
		&& o_wr_initial_q != $past(op[0], 2)) else $error("write mode");
	tag_ops_a: assert property (wr & op[2:1] == 2'b10 |-> ##2
		o_tag_or_q == $past(op[0], 2) && o_tag_replace_q != o_tag_or_q
		&& o_wr_word_q == 3'h0) else $error("tag op");
	blend_start_a: assert property (wr & op == 3'h6 |-> ##2
		o_blend_init_q && !o_wr_valid_q
		&& o_wr_word_q == $past(ad[2:0], 2)) else $error("blend op");
	mask_load_a: assert property (rw & ad == 6'h00 |-> ##3
		o_plane_write_mask_q == ($past(i_pixel_data_bus, 2) & $past(bm, 3)
		| $past(o_plane_write_mask_q) & ~$past(bm, 3)))
		else $error("mask load");
	hit_clear_a: assert property (clr_s |-> ##6 o_hit_n_q)
		else $error("hit clear");
	hit_force_a: assert property (ccr_wr ##1
		i_pixel_data_bus[25:24] == 2'b11 |-> ##6 !o_hit_n_q)
		else $error("hit set");
	pick_off_a: assert property (ccr_wr ##1
		i_pixel_data_bus[27:26] == 2'b10 |-> ##[1:7] !o_pick_enable_q)
		else $error("pick off");
	hit_set_a: assert property (wr & op[2:1] == 2'b01 ##5
		o_pass_out_q & (&i_pass_in) |=> o_pb_write_enable_q ##1
		(!o_hit_n_q || !$past(o_pick_enable_q))) else $error("hit pass");
	reset_val_a: assert property ($fell(i_rst) |-> o_pick_enable_q
		&& o_hit_n_q && o_plane_write_mask_q == 32'hffff_ffff)
		else $error("reset state");
	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	clr_c: cover property (clr_s);
	pass_c: cover property (o_pb_write_enable_q);
	ident_c: cover property (rd & op == 3'h7 & ad == `PAC_A_IDENT);
	mask_c: cover property (rw & ad == 6'h00);
endmodule
bind pac_top pac_top_checker u_chk (.*);

// [test_pixel_alu_command_port.sv]
`timescale 1ns/10ps
`include "pac_defs.vh"
`define CHK(nm, ex, got) begin n_checks = n_checks + 1; \
	if ((got) !== (ex)) begin errors = errors + 1; \
	$display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_pixel_alu_command_port;
	reg clk = 0, rst = 1, ws = 0, want = 0;
	reg [1:0] en = 0, dsel = 0;
	reg [2:0] opc = 0, o;
	reg [5:0] addr = 0, a, ra;
	reg [3:0] be = 0, dx = 0, px = 0, shx, b, x;
	reg [31:0] dq = 0, pd = 0, d, sh [0:15];
	integer seed = 32'h0b72f3c7, errors = 0, n_checks = 0, cyc = 0, k, j;
	wire oe, rdq, wv, wst, wini, trp, tor, bli, mat, ord, pout, pbwe, pick, hitn;
	wire [1:0] pin;
	wire [2:0] blk, wrd;
	wire [3:0] wext;
	wire [5:0] cadr;
	wire [31:0] dout, pbd, wdata, biten, pm;
	wire [35:0] cop;
	wire [511:0] sctl;
	pac_top DUT (.i_clock(clk), .i_rst(rst), .i_op_enable_pair(en),
		.i_op_write_select(ws), .i_op_code_field(opc),
		.i_pixel_port_address(addr), .i_byte_lane_enables(be),
		.i_pixel_data_bus(dq), .i_data_extension_bits(dx),
		.i_pb_read_data(pbd), .i_match_result(mat), .i_order_result(ord),
		.i_pass_in(pin), .o_pixel_data_bus(dout), .o_pixel_data_oe(oe),
		.o_pb_read_q(rdq), .o_cmd_addr_q(cadr), .o_wr_valid_q(wv),
		.o_wr_stateful_q(wst), .o_wr_initial_q(wini), .o_tag_replace_q(trp),
		.o_tag_or_q(tor), .o_blend_init_q(bli), .o_wr_block_q(blk),
		.o_wr_word_q(wrd), .o_wr_data_q(wdata), .o_wr_ext_q(wext),
		.o_wr_bit_en_q(biten), .o_stage_ctrl_q(sctl),
		.o_plane_write_mask_q(pm), .o_constant_operand_q(cop),
		.o_pass_out_q(pout), .o_pb_write_enable_q(pbwe),
		.o_pick_enable_q(pick), .o_hit_n_q(hitn));
	pac_far_model u_far (.i_clock(clk), .i_pb_read_q(rdq), .i_cmd_addr_q(cadr),
		.i_pass_want(want), .i_drop_sel(dsel), .o_pb_read_data(pbd),
		.o_match_result(mat), .o_order_result(ord), .o_pass_in(pin));
	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	function [31:0] bm(input [3:0] e);
		bm = {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
	endfunction
	function [31:0] rstv(input [3:0] i);
		case (i)
		4'h0: rstv = `PAC_RST_PLANE_MASK;
		4'h4: rstv = `PAC_RST_RASTER_BLEND;
		4'h5: rstv = `PAC_RST_COMPARE_PICK & 32'hf5ff_ffff;
		4'ha: rstv = `PAC_RST_STENCIL_PLANE;
		4'hb: rstv = `PAC_RST_STENCIL_FUNC;
		4'he: rstv = `PAC_RST_PASS_SELECT;
		default: rstv = `PAC_RST_ZERO;
		endcase
	endfunction
	function [31:0] slot(input [3:0] i, input sl);
		if (i == 7 || i == 12 || i == 13) slot = 0;
		else if (sl && i == 4) slot = `PAC_SL_RASTER_BLEND;
		else if (sl && i == 10) slot = `PAC_SL_STENCIL_PLANE;
		else if (sl && i == 11) slot = `PAC_SL_STENCIL_FUNC;
		else if (sl && (i == 5 || i == 6 || i == 8 || i == 9)) slot = 0;
		else slot = sh[i];
	endfunction
	// ----------------------------------------------------------------
	// drivers: data follows its opcode by one cycle
	// ----------------------------------------------------------------
	task iss(input w, input [2:0] op, input [5:0] ad, input [3:0] e,
		input [31:0] dd, input [3:0] xx);
		begin
			@(negedge clk);
			en = 2'b11; ws = w; opc = op; addr = ad; be = e;
			dq = pd; dx = px; pd = dd; px = xx;
		end
	endtask
	task nop(input integer n);
		repeat (n) begin
			@(negedge clk);
			en = {$random(seed)} % 3; ws = $random(seed); opc = $random(seed);
			addr = $random(seed); be = $random(seed);
			dq = pd; dx = px; pd = $random(seed); px = $random(seed);
		end
	endtask
	task wreg(input [5:0] i, input [3:0] e, input [31:0] dd, input [3:0] xx);
		begin
			iss(1, 3'h7, i, e, dd, xx);
			if (i < 16 && i != 7 && i != 12 && i != 13)
				sh[i] = dd & bm(e) | sh[i] & ~bm(e);
			if (i == 1 && e[3]) shx = xx;
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			errors = errors + 1;
			print_verdict;
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		for (k = 0; k < 16; k = k + 1) sh[k] = rstv(k);
		shx = 0;
		repeat (12) @(negedge clk);
		rst = 0;
		nop(1);
		`CHK("reset", {4'h0, 32'h0}, cop)
		`CHK("pick hit", 2'b11, {pick, hitn})
		for (k = 0; k < 60; k = k + 1) begin
			ra = {$random(seed)} % 20; d = $random(seed);
			b = $random(seed); x = $random(seed);
			if (ra == 5) d[27:24] = 4'h0;
			wreg(ra, b, d, x);
			o = {$random(seed)} % 7; a = $random(seed);
			d = $random(seed); x = $random(seed);
			iss(1, o, a, $random(seed), d, x);
			nop(2);
			`CHK("valid", o < 3'h4, wv)
			if (o < 4) `CHK("mode", {o[1], ~o[0]}, {wst, wini})
			`CHK("tags", {o == 4, o == 5, o == 6}, {trp, tor, bli})
			`CHK("block", a[5:3], blk)
			`CHK("word", o == 4 || o == 5 ? 3'h0 : a[2:0], wrd)
			`CHK("wdata", {x, d}, {wext, wdata})
			`CHK("bit en", o > 3 ? 32'h0 : o[1] ? sh[0] : 32'hffff_ffff, biten)
			for (j = 0; j < 16; j = j + 1)
				`CHK("slot", slot(j, o < 2), sctl[32*j +: 32])
			`CHK("plane mask", sh[0], pm)
			`CHK("constant", {shx, sh[1]}, cop)
		end
		for (k = 0; k < 9; k = k + 1) begin
			o = k == 8 ? 3'h7 : k; a = k == 8 ? 6'h06 : 6'h07;
			b = $random(seed) | 1;
			iss(0, o, a, b, $random(seed), 0);
			nop(2);
			`CHK("oe", o == 0 || o == 7 && a == 7, oe)
			`CHK("rdata", o == 0 ? {4{2'b10, a}} : o == 7 && a == 7 ?
				`PAC_IDENT_DEFAULT & bm(b) : 32'h0, dout)
		end
		for (k = 0; k < 5; k = k + 1) begin
			want = k == 4; dsel = k;
			iss(1, 3'h3, $random(seed), 4'hf, $random(seed), 0);
			nop(6);
			`CHK("pass", k == 4, pbwe)
			`CHK("pass out", k > 1, pout)
			nop(1);
			`CHK("hit", k != 4, hitn)
		end
		nop(20);
		`CHK("hit hold", 1'b0, hitn)
		wreg(5, 4'h8, 32'h0200_0000, 0);
		iss(1, 3'h3, $random(seed), 4'hf, $random(seed), 0);
		nop(6);
		`CHK("hit clear", 1'b1, hitn)
		nop(1);
		`CHK("hit again", 1'b0, hitn)
		wreg(5, 4'h8, 32'h0a00_0000, 0);
		nop(10);
		`CHK("pick off", 2'b01, {pick, hitn})
		iss(1, 3'h2, $random(seed), 4'hf, $random(seed), 0);
		nop(10);
		`CHK("no pick", 1'b1, hitn)
		wreg(5, 4'h8, 32'h0e00_0000, 0);
		nop(10);
		`CHK("init", 2'b11, {pick, hitn})
		wreg(5, 4'h8, 32'h0300_0000, 0);
		nop(10);
		`CHK("hit set", 1'b0, hitn)
		wreg(5, 4'h8, 32'h0e00_0000, 0);
		wreg(5, 4'h7, 32'h0300_0000, 0);
		nop(10);
		`CHK("lane gate", 2'b11, {pick, hitn})
		print_verdict;
	end
endmodule
